//--- dv/scs_board_model.sv
`timescale 1ns/10ps
module scs_board_model
  import scs_pkg::*;
(
  input  wire logic       ref_clk_i,
  output logic            reset_o,
  output logic            hitless_o,
  output logic [1:0]      mode_sel_o,
  output logic            en0_o,
  output logic            en1_o,
  output logic            fail_o,
  output logic [7:0]      refs_o
);
  // control pins have pull-ups, so they idle high; reset starts asserted
  initial begin
    reset_o = 1'b1;
    hitless_o = 1'b1;
    mode_sel_o = 2'h3;
    en0_o = 1'b1;
    en1_o = 1'b1;
    fail_o = 1'b0;
    refs_o = 8'h00;
  end

  // each reference toggles at its own rate so every select shows a distinct pattern
  always @(posedge ref_clk_i) begin
    refs_o <= refs_o + 8'h01;
  end

  // board holds reset asserted for the minimum pulse width, pins left as set
  task automatic apply_reset();
    @(posedge ref_clk_i);
    reset_o <= 1'b1;
    repeat (RESET_MIN_CYC) @(posedge ref_clk_i);
    reset_o <= 1'b0;
  endtask : apply_reset

  // change the control pin levels just after an edge
  task automatic set_pins(input logic hs, input logic [1:0] md, input logic e0, e1, f);
    @(posedge ref_clk_i);
    hitless_o <= hs;
    mode_sel_o <= md;
    en0_o <= e0;
    en1_o <= e1;
    fail_o <= f;
  endtask : set_pins
endmodule : scs_board_model

//--- dv/scs_sync_ctrl_tb.sv
`timescale 1ns/10ps
module scs_sync_ctrl_tb
  import scs_pkg::*;
;
  logic        clk, rst, wr, rd, fail, hs, en0, en1, fb, sref, oe0, oe1, hold, realign;
  logic [7:0]  addr, refs;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  msel, mode;
  logic        p1c, p1s, d0p, d0n, d1p, d1n;
  int          n_errors = 0;
  int          n_checks = 0;

  scs_board_model scs_board_model_inst (.ref_clk_i(clk), .reset_o(rst), .hitless_o(hs),
    .mode_sel_o(msel), .en0_o(en0), .en1_o(en1), .fail_o(fail), .refs_o(refs));

  scs_sync_ctrl scs_sync_ctrl_inst (.ref_clk_i(clk), .reset_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .refs_i(refs),
    .ref_fail_i(fail), .primary_loop_hitless_enable_i(hs),
    .primary_loop_mode_select_bit0_i(msel[0]), .primary_loop_mode_select_bit1_i(msel[1]),
    .diff_output_zero_enable_i(en0), .diff_output_one_enable_i(en1),
    .synth_b_primary_clock_o(p1c), .synth_b_secondary_clock_o(p1s),
    .loop_feedback_clock_out_o(fb), .secondary_loop_selected_ref_out_o(sref),
    .diff_clock_zero_pos_o(d0p), .diff_clock_zero_neg_o(d0n), .diff_clock_zero_oe_o(oe0),
    .diff_clock_one_pos_o(d1p), .diff_clock_one_neg_o(d1n), .diff_clock_one_oe_o(oe1),
    .primary_loop_holdover_flag_o(hold), .phase_realign_o(realign),
    .primary_loop_mode_o(mode));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // single-cycle register strobes, changed just after an edge
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_read

  // every pin value sampled during reset picks its mapped mode
  task automatic t_reset_modes();
    for (int i = 0; i < 4; i++) begin
      scs_board_model_inst.set_pins(1'b1, 2'(i), 1'b1, 1'b1, 1'b0);
      scs_board_model_inst.apply_reset();
      repeat (2) @(posedge clk);
      #1;
      check(32'(mode), 32'(MODE_MAP_DEF[2*i+:2]), "reset mode");
      check(32'(hold), 32'(i == 2), "holdover");
    end
  endtask : t_reset_modes

  // default frequencies, unmapped read, out-of-range writes ignored
  task automatic t_freqs();
    bus_read(ADDR_P1_FREQ, rv);
    check(rv, 32'd1544, "p1 default");
    bus_read(ADDR_SEC_RAT, rv);
    check(rv, 32'h9, "sec ratio");
    bus_read(ADDR_DIFF0_FQ, rv);
    check(rv, 32'd155520, "diff0 default");
    bus_read(ADDR_DIFF1_FQ, rv);
    check(rv, 32'd622080, "diff1 default");
    bus_read(8'h1C, rv);
    check(rv, 32'h0, "unmapped");
    bus_write(ADDR_P1_FREQ, 32'd5);
    bus_read(ADDR_P1_FREQ, rv);
    check(rv, 32'd1544, "p1 odd");
    bus_write(ADDR_P1_FREQ, 32'd2);
    bus_read(ADDR_P1_FREQ, rv);
    check(rv, 32'd2, "p1 2k");
    bus_write(ADDR_P1_FREQ, 32'd77768);
    bus_read(ADDR_P1_FREQ, rv);
    check(rv, 32'd2, "p1 high");
  endtask : t_freqs

  // pins steer the mode after reset, then the register takes over
  task automatic t_mode();
    scs_board_model_inst.set_pins(1'b1, 2'h2, 1'b1, 1'b1, 1'b0);
    repeat (2) @(posedge clk);
    #1 check(32'(mode), 32'(MODE_FREERUN), "mode early");
    @(posedge clk);
    #1 check(32'(mode), 32'(MODE_HOLDOVER), "mode pins");
    @(posedge clk);
    #1 check(32'(hold), 32'h1, "hold pins");
    bus_read(ADDR_STATUS, rv);
    check(rv, 32'h3E, "status");
    bus_write(ADDR_CTRL, 32'h35);
    repeat (2) @(posedge clk);
    #1 check(32'(mode), 32'(MODE_FREERUN), "mode reg");
    check(32'(hold), 32'h0, "hold off");
    bus_write(ADDR_CTRL, 32'h05);
    scs_board_model_inst.set_pins(1'b1, 2'h2, 1'b1, 1'b1, 1'b1);
    repeat (3) @(posedge clk);
    #1 check(32'(hold), 32'h1, "hold auto");
    bus_write(ADDR_CTRL, 32'h01);
  endtask : t_mode

  // driver enables follow their pins three edges later
  task automatic t_oe();
    logic [1:0] tbl [3] = '{2'b10, 2'b01, 2'b11};
    logic [1:0] old;
    old = 2'b11;
    for (int i = 0; i < 3; i++) begin
      scs_board_model_inst.set_pins(1'b1, 2'h2, tbl[i][0], tbl[i][1], 1'b0);
      repeat (2) @(posedge clk);
      #1 check(32'({oe1, oe0}), 32'(old), "oe early");
      @(posedge clk);
      #1 check(32'({oe1, oe0}), 32'(tbl[i]), "oe");
      old = tbl[i];
    end
  endtask : t_oe

  // reference copies and phase realignment from pin and register
  task automatic t_refs();
    logic [7:0] prev;
    bus_write(ADDR_REFSEL, 32'h21);
    check(32'(realign), 32'h0, "hitless pin");
    repeat (6) begin
      @(posedge clk);
      prev = refs;
      #1 check(32'(fb), 32'(prev[1]), "feedback");
      check(32'(sref), 32'(prev[2]), "sec ref");
    end
    scs_board_model_inst.set_pins(1'b0, 2'h2, 1'b1, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    bus_write(ADDR_REFSEL, 32'h22);
    check(32'(realign), 32'h1, "realign pin");
    @(posedge clk);
    #1 check(32'(realign), 32'h0, "realign end");
    bus_write(ADDR_CTRL, 32'h03);
    bus_write(ADDR_REFSEL, 32'h23);
    check(32'(realign), 32'h0, "hitless reg");
    bus_write(ADDR_CTRL, 32'h02);
    bus_write(ADDR_REFSEL, 32'h24);
    check(32'(realign), 32'h1, "realign reg");
  endtask : t_refs

  // synthesised clocks: rising edges in a 400-cycle window match the programmed rates
  task automatic t_clocks();
    int         cnt [4];
    int         khz [4];
    int         want;
    logic [3:0] now;
    logic [3:0] last;
    khz = '{8000, 16000, 4000, 10000};
    cnt = '{0, 0, 0, 0};
    bus_write(ADDR_P1_FREQ, 32'd8000);
    bus_write(ADDR_DIFF0_FQ, 32'd4000);
    bus_write(ADDR_DIFF1_FQ, 32'd10000);
    @(posedge clk);
    #1 last = {d1p, d0p, p1s, p1c};
    repeat (400) begin
      @(posedge clk);
      #1 now = {d1p, d0p, p1s, p1c};
      for (int k = 0; k < 4; k++) begin
        if (now[k] && !last[k]) cnt[k]++;
      end
      last = now;
      n_checks++;
      if (d0n !== ~d0p || d1n !== ~d1p) begin
        n_errors++;
        $display("Error at %0t: differential legs not complementary", $time);
      end
    end
    // secondary runs at twice the primary under the default ratio
    for (int k = 0; k < 4; k++) begin
      want = 400 * khz[k] / REF_CLK_KHZ;
      n_checks++;
      if (cnt[k] < want - 1 || cnt[k] > want + 1) begin
        n_errors++;
        $display("Error at %0t: clock %0d gave %0d edges exp %0d", $time, k, cnt[k], want);
      end
    end
  endtask : t_clocks

  // watchdog cuts a hang short
  initial begin
    #200us;
    n_errors++;
    end_of_test();
  end

  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    t_reset_modes();
    scs_board_model_inst.set_pins(1'b1, 2'h3, 1'b1, 1'b1, 1'b0);
    scs_board_model_inst.apply_reset();
    t_freqs();
    t_mode();
    t_oe();
    t_refs();
    t_clocks();
    end_of_test();
  end
endmodule : scs_sync_ctrl_tb

//--- rtl/scs_nco.sv
`timescale 1ns/10ps
module scs_nco
  import scs_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire logic              clear_i,
  input  wire logic [FREQ_W-1:0] freq_khz_i,
  output logic                   clk_o
);

  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic [ACC_W+17:0] step_full;

  // step scaled from kHz; a clear realigns the phase to zero
  always_comb begin
    step_full = {18'h0, 12'h0, freq_khz_i} * (ACC_W + 18)'(STEP_PER_KHZ);
    if (clear_i) begin
      next_acc = '0;
    end else begin
      next_acc = acc + step_full[ACC_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      acc   <= '0;
      clk_o <= 1'b0;
    end else begin
      acc   <= next_acc;
      clk_o <= next_acc[ACC_W-1];
    end
  end

endmodule : scs_nco

//--- rtl/scs_pkg.sv
package scs_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_REFSEL   = 8'h04;
  localparam logic [7:0] ADDR_P1_FREQ  = 8'h08;
  localparam logic [7:0] ADDR_SEC_RAT  = 8'h0C;
  localparam logic [7:0] ADDR_DIFF0_FQ = 8'h10;
  localparam logic [7:0] ADDR_DIFF1_FQ = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;

  // control, reference select and ratio register field positions
  localparam int CTRL_HS_REG_BIT  = 0;
  localparam int CTRL_HS_SRC_BIT  = 1;
  localparam int CTRL_MODE_SRC    = 2;
  localparam int CTRL_MODE_LSB    = 4;
  localparam int REFSEL_PRI_LSB   = 0;
  localparam int REFSEL_SEC_LSB   = 4;
  localparam int SECRAT_UP_BIT    = 3;

  // primary loop mode codes
  localparam logic [1:0] MODE_AUTO     = 2'h0;
  localparam logic [1:0] MODE_NORMAL   = 2'h1;
  localparam logic [1:0] MODE_HOLDOVER = 2'h2;
  localparam logic [1:0] MODE_FREERUN  = 2'h3;
  // pin value i selects mode MODE_MAP_DEF[2i+1:2i]
  localparam logic [7:0] MODE_MAP_DEF  = 8'hE4;

  // frequencies in kHz
  localparam int FREQ_W = 20;
  localparam logic [19:0] P1_FREQ_DEF    = 20'd1544;
  localparam logic [19:0] DIFF0_FREQ_DEF = 20'd155520;
  localparam logic [19:0] DIFF1_FREQ_DEF = 20'd622080;
  localparam logic [19:0] SYN_FREQ_MIN   = 20'd2;
  localparam logic [19:0] SYN_FREQ_MAX   = 20'd77760;
  localparam logic [19:0] DIFF_FREQ_MAX  = 20'd622080;
  // secondary defaults to twice the primary: 3.088 MHz
  localparam logic [2:0] SEC_SHIFT_DEF   = 3'h1;
  localparam logic       SEC_UP_DEF      = 1'b1;
  localparam logic       HS_REG_DEF      = 1'b1;

  // reference clock and phase accumulator step per kHz (2^32 / 40000 kHz)
  localparam int REF_CLK_KHZ   = 40000;
  localparam int ACC_W         = 32;
  localparam int STEP_PER_KHZ  = int'((64'd1 << ACC_W) / REF_CLK_KHZ);
  localparam int RESET_MIN_NS  = 300;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // software controls carried together
  typedef struct packed {
    logic       hs_reg;
    logic       hs_src;
    logic       mode_src;
    logic [1:0] mode_reg;
    logic [2:0] pri_sel;
    logic [2:0] sec_sel;
    logic       sec_up;
    logic [2:0] sec_shift;
  } scs_cfg_t;

  // frequency words carried together
  typedef struct packed {
    logic [19:0] p1;
    logic [19:0] diff0;
    logic [19:0] diff1;
  } scs_freq_t;

endpackage : scs_pkg

//--- rtl/scs_sync_ctrl.sv
// What this block does
// - synth B primary clock: 8 kHz multiples to 77.76 MHz or 2 kHz, default 1.544 MHz
// - synth B secondary derived from primary, 2 kHz to 77.76 MHz, default 3.088 MHz
// - feedback clock output copies the selected primary reference
// - secondary loop selected reference copied out, switching not hitless
// - differential output zero configurable, default 155.52 MHz
// - differential output one configurable, default 622.08 MHz
// - reset input held asserted puts the block in its reset state
// - hitless enable high: reference switch leaves output phase untouched
// - hitless enable low: reference switch realigns synth B primary and secondary output phase to reference
// - hitless enable also controllable from a software register
// - mode select pins sampled during reset set the default mode
// - after reset mode comes from pins or the mode register
// - differential output zero driver enabled by its enable pin, else tristated
// - differential output one driver enabled by its enable pin, else tristated
// - holdover flag high whenever primary loop is in holdover
`timescale 1ns/10ps
module scs_sync_ctrl
  import scs_pkg::*;
#(
  parameter logic [7:0] MODE_MAP = MODE_MAP_DEF
) (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [31:0]     rdata_o,
  input  wire logic [7:0] refs_i,
  input  wire logic       ref_fail_i,
  input  wire logic       primary_loop_hitless_enable_i,
  input  wire logic       primary_loop_mode_select_bit0_i,
  input  wire logic       primary_loop_mode_select_bit1_i,
  input  wire logic       diff_output_zero_enable_i,
  input  wire logic       diff_output_one_enable_i,
  output logic            synth_b_primary_clock_o,
  output logic            synth_b_secondary_clock_o,
  output logic            loop_feedback_clock_out_o,
  output logic            secondary_loop_selected_ref_out_o,
  output logic            diff_clock_zero_pos_o,
  output logic            diff_clock_zero_neg_o,
  output logic            diff_clock_zero_oe_o,
  output logic            diff_clock_one_pos_o,
  output logic            diff_clock_one_neg_o,
  output logic            diff_clock_one_oe_o,
  output logic            primary_loop_holdover_flag_o,
  output logic            phase_realign_o,
  output logic [1:0]      primary_loop_mode_o
);

  // pin synchronisers: bit0 hitless, 2:1 mode, 3 diff_output_zero_enable, 4 diff_output_one_enable
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_raw;

  // software state
  scs_cfg_t   cfg;
  scs_cfg_t   next_cfg;
  scs_freq_t  frq;
  scs_freq_t  next_frq;
  logic [31:0] next_rdata;

  // derived state
  logic [1:0]  mode;
  logic [1:0]  next_mode;
  logic [19:0] sec_freq;
  logic [19:0] next_sec_freq;
  logic [26:0] sec_calc;
  logic        hs_eff;
  logic        next_realign;
  logic        fb_q;
  logic        sec_ref_q;
  logic        hold_q;
  logic        oe0_q;
  logic        oe1_q;
  logic        p1_clk;
  logic        p1s_clk;
  logic        d0_clk;
  logic        d1_clk;
  logic [19:0] wfreq;

  // two-flop synchronisers, unreset so they keep sampling during reset
  assign pin_raw = {diff_output_one_enable_i, diff_output_zero_enable_i,
                    primary_loop_mode_select_bit1_i, primary_loop_mode_select_bit0_i,
                    primary_loop_hitless_enable_i};
  always_ff @(posedge ref_clk_i) begin
    pin_meta <= pin_raw;
    pin_sync <= pin_meta;
  end

  // mode code for a two-bit pin value
  function automatic logic [1:0] map_mode(input logic [1:0] sel);
    map_mode = MODE_MAP[{sel, 1'b0} +: 2];
  endfunction : map_mode

  // hitless enable from pin or register
  assign hs_eff = cfg.hs_src ? cfg.hs_reg : pin_sync[0];
  assign wfreq  = wdata_i[19:0];

  // register writes and read data
  always_comb begin
    next_cfg   = cfg;
    next_frq   = frq;
    next_rdata = 32'h0000_0000;
    if (wr_i) begin
      case (addr_i)
        ADDR_CTRL: begin
          next_cfg.hs_reg   = wdata_i[CTRL_HS_REG_BIT];
          next_cfg.hs_src   = wdata_i[CTRL_HS_SRC_BIT];
          next_cfg.mode_src = wdata_i[CTRL_MODE_SRC];
          next_cfg.mode_reg = wdata_i[CTRL_MODE_LSB +: 2];
        end
        ADDR_REFSEL: begin
          next_cfg.pri_sel = wdata_i[REFSEL_PRI_LSB +: 3];
          next_cfg.sec_sel = wdata_i[REFSEL_SEC_LSB +: 3];
        end
        ADDR_P1_FREQ: begin
          // only 2 kHz or nonzero 8 kHz multiples up to the limit are taken
          if (wfreq == SYN_FREQ_MIN ||
              (wfreq[2:0] == 3'h0 && wfreq != 20'h0 && wfreq <= SYN_FREQ_MAX)) begin
            next_frq.p1 = wfreq;
          end
        end
        ADDR_SEC_RAT: begin
          next_cfg.sec_shift = wdata_i[2:0];
          next_cfg.sec_up    = wdata_i[SECRAT_UP_BIT];
        end
        ADDR_DIFF0_FQ: begin
          if (wfreq != 20'h0 && wfreq <= DIFF_FREQ_MAX) begin
            next_frq.diff0 = wfreq;
          end
        end
        ADDR_DIFF1_FQ: begin
          if (wfreq != 20'h0 && wfreq <= DIFF_FREQ_MAX) begin
            next_frq.diff1 = wfreq;
          end
        end
        default: begin
          next_cfg = cfg;
        end
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        ADDR_CTRL:     next_rdata = {26'h0, cfg.mode_reg, 1'b0, cfg.mode_src,
                                     cfg.hs_src, cfg.hs_reg};
        ADDR_REFSEL:   next_rdata = {25'h0, cfg.sec_sel, 1'b0, cfg.pri_sel};
        ADDR_P1_FREQ:  next_rdata = {12'h0, frq.p1};
        ADDR_SEC_RAT:  next_rdata = {28'h0, cfg.sec_up, cfg.sec_shift};
        ADDR_DIFF0_FQ: next_rdata = {12'h0, frq.diff0};
        ADDR_DIFF1_FQ: next_rdata = {12'h0, frq.diff1};
        ADDR_STATUS:   next_rdata = {26'h0, oe1_q, oe0_q, hold_q, hs_eff, mode};
        default:       next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // software registers with their reset defaults
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cfg.hs_reg    <= HS_REG_DEF;
      cfg.hs_src    <= 1'b0;
      cfg.mode_src  <= 1'b0;
      cfg.mode_reg  <= MODE_AUTO;
      cfg.pri_sel   <= 3'h0;
      cfg.sec_sel   <= 3'h0;
      cfg.sec_up    <= SEC_UP_DEF;
      cfg.sec_shift <= SEC_SHIFT_DEF;
      frq.p1        <= P1_FREQ_DEF;
      frq.diff0     <= DIFF0_FREQ_DEF;
      frq.diff1     <= DIFF1_FREQ_DEF;
      rdata_o       <= 32'h0000_0000;
    end else begin
      cfg     <= next_cfg;
      frq     <= next_frq;
      rdata_o <= next_rdata;
    end
  end

  // mode, secondary frequency and realign pulse
  always_comb begin
    sec_calc = cfg.sec_up ? ({7'h0, frq.p1} << cfg.sec_shift)
                          : ({7'h0, frq.p1} >> cfg.sec_shift);
    if (sec_calc < {7'h0, SYN_FREQ_MIN}) begin
      next_sec_freq = SYN_FREQ_MIN;
    end else if (sec_calc > {7'h0, SYN_FREQ_MAX}) begin
      next_sec_freq = SYN_FREQ_MAX;
    end else begin
      next_sec_freq = sec_calc[19:0];
    end
    if (reset_i) begin
      next_mode = map_mode(pin_sync[2:1]);
    end else if (cfg.mode_src) begin
      next_mode = cfg.mode_reg;
    end else begin
      next_mode = map_mode(pin_sync[2:1]);
    end
    // a primary reference change realigns phase unless hitless
    next_realign = (next_cfg.pri_sel != cfg.pri_sel) && !hs_eff;
  end

  // mode is loaded from the pins while reset is held
  always_ff @(posedge ref_clk_i) begin
    mode <= next_mode;
    if (reset_i) begin
      sec_freq        <= P1_FREQ_DEF;
      phase_realign_o <= 1'b0;
      fb_q            <= 1'b0;
      sec_ref_q       <= 1'b0;
      hold_q          <= 1'b0;
      oe0_q           <= 1'b0;
      oe1_q           <= 1'b0;
    end else begin
      sec_freq        <= next_sec_freq;
      phase_realign_o <= next_realign;
      fb_q            <= refs_i[cfg.pri_sel];
      sec_ref_q       <= refs_i[cfg.sec_sel];
      hold_q          <= (mode == MODE_HOLDOVER) || (mode == MODE_AUTO && ref_fail_i);
      oe0_q           <= pin_sync[3];
      oe1_q           <= pin_sync[4];
    end
  end

  // synthesised clocks; primary pair realigns with the reference
  scs_nco u_p1_pri (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clear_i   (phase_realign_o),
    .freq_khz_i(frq.p1),
    .clk_o     (p1_clk)
  );
  scs_nco u_p1_sec (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clear_i   (phase_realign_o),
    .freq_khz_i(sec_freq),
    .clk_o     (p1s_clk)
  );
  scs_nco u_diff0 (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clear_i   (1'b0),
    .freq_khz_i(frq.diff0),
    .clk_o     (d0_clk)
  );
  scs_nco u_diff1 (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clear_i   (1'b0),
    .freq_khz_i(frq.diff1),
    .clk_o     (d1_clk)
  );

  // pin outputs
  assign synth_b_primary_clock_o           = p1_clk;
  assign synth_b_secondary_clock_o         = p1s_clk;
  assign loop_feedback_clock_out_o         = fb_q;
  assign secondary_loop_selected_ref_out_o = sec_ref_q;
  assign diff_clock_zero_pos_o             = d0_clk;
  assign diff_clock_zero_neg_o             = ~d0_clk;
  assign diff_clock_zero_oe_o              = oe0_q;
  assign diff_clock_one_pos_o              = d1_clk;
  assign diff_clock_one_neg_o              = ~d1_clk;
  assign diff_clock_one_oe_o               = oe1_q;
  assign primary_loop_holdover_flag_o      = hold_q;
  assign primary_loop_mode_o               = mode;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  chk_reset_freq_defaults: assert property (
    $past(reset_i) |-> frq.p1 == P1_FREQ_DEF && frq.diff0 == DIFF0_FREQ_DEF
                       && frq.diff1 == DIFF1_FREQ_DEF)
    else $error("frequency defaults wrong after reset");
  chk_sec_in_range: assert property (
    !$past(reset_i) |-> sec_freq >= SYN_FREQ_MIN && sec_freq <= SYN_FREQ_MAX)
    else $error("secondary frequency out of range");
  chk_fb_follows_ref: assert property (
    1'b1 |=> loop_feedback_clock_out_o == $past(refs_i[cfg.pri_sel]))
    else $error("feedback clock not the selected reference");
  chk_sec_ref_copy: assert property (
    1'b1 |=> secondary_loop_selected_ref_out_o == $past(refs_i[cfg.sec_sel]))
    else $error("secondary reference copy wrong");
  chk_hitless_no_realign: assert property (
    hs_eff && !wr_i |=> !phase_realign_o)
    else $error("realign while hitless");
  chk_realign_on_switch: assert property (
    wr_i && addr_i == ADDR_REFSEL && wdata_i[2:0] != cfg.pri_sel && !hs_eff
    |=> phase_realign_o ##1 !phase_realign_o)
    else $error("no single realign pulse on reference switch");
  chk_mode_from_pins: assert property (
    !cfg.mode_src |=> mode == map_mode($past(pin_sync[2:1])))
    else $error("mode does not follow pins");
  chk_mode_sampled: assert property (
    $past(reset_i) |-> mode == map_mode($past(pin_sync[2:1])))
    else $error("mode not sampled during reset");
  chk_diff0_driver: assert property (
    diff_output_zero_enable_i [*3] |=> diff_clock_zero_oe_o)
    else $error("diff0 driver not enabled");
  chk_diff1_driver: assert property (
    !diff_output_one_enable_i [*3] |=> !diff_clock_one_oe_o)
    else $error("diff1 driver not tristated");
  chk_holdover_flag: assert property (
    mode == MODE_HOLDOVER |=> primary_loop_holdover_flag_o)
    else $error("holdover flag low in holdover");

endmodule : scs_sync_ctrl
